// File: shared/pdas_defs.svh
`ifndef PDAS_DEFS_SVH
`define PDAS_DEFS_SVH

// register byte offsets
`define PDAS_OFS_DEADBAND 8'h00
`define PDAS_OFS_SHUTDOWN 8'h04
`define PDAS_OFS_MODE 8'h08
`define PDAS_OFS_STATUS 8'h0C

// deadband_restart_ctrl fields
`define PDAS_DB_RESTART_BIT 7
`define PDAS_DB_COUNT_MSB 6
`define PDAS_DB_COUNT_LSB 0

// auto_shutdown_ctrl fields
`define PDAS_AS_STATUS_BIT 7
`define PDAS_AS_SRC_MSB 6
`define PDAS_AS_SRC_LSB 4
`define PDAS_AS_AC_MSB 3
`define PDAS_AS_AC_LSB 2
`define PDAS_AS_BD_MSB 1
`define PDAS_AS_BD_LSB 0

// pwm_mode_control fields
`define PDAS_MC_CFG_MSB 7
`define PDAS_MC_CFG_LSB 6
`define PDAS_MC_ENABLE_BIT 3
`define PDAS_MC_POL_BD_BIT 1
`define PDAS_MC_POL_AC_BIT 0

// reset values
`define PDAS_RST_DEADBAND 8'h00
`define PDAS_RST_SHUTDOWN 8'h00
`define PDAS_RST_MODE 8'h00

// timing: one instruction cycle is four oscillator periods
`define PDAS_TOSC_PER_TCY 4
`define PDAS_CLK_PERIOD_PS 25000
`define PDAS_TCY_PS 100000

`endif

// File: shared/pdas_pkg.sv
package pdas_pkg;

	typedef enum logic [1:0]
	{
		PDAS_CFG_SINGLE = 2'h0,
		PDAS_CFG_HALF = 2'h1,
		PDAS_CFG_FULL_FWD = 2'h2,
		PDAS_CFG_FULL_REV = 2'h3
	} pdas_cfg_t;

	// gray-coded dead-band sequencer: wait A, drive A, wait B, drive B
	typedef enum logic [1:0]
	{
		PDAS_DB_A_WAIT = 2'h0,
		PDAS_DB_A_ON = 2'h1,
		PDAS_DB_B_WAIT = 2'h3,
		PDAS_DB_B_ON = 2'h2
	} pdas_db_state_t;

	typedef enum logic [1:0]
	{
		PDAS_LVL_LOW = 2'h0,
		PDAS_LVL_HIGH = 2'h1,
		PDAS_LVL_TRI = 2'h2
	} pdas_level_t;

endpackage

// File: design/pdas_top.sv
// Behaviour
// - half-bridge: delay each inactive-to-active edge by count times four clocks
// - dead-band count is bits 6:0 of deadband register, read/write, reset zero
// - dead band longer than the phase keeps that output inactive all cycle
// - half-bridge drives pwm on A, complement on B, delay on rising edges only
// - auto-shutdown works in every output configuration on active pins
// - three-bit source select picks comparators and fault pin per encoding
// - a low fault pin is a shutdown event when selected
// - shutdown forces pin levels at once, without waiting for a clock
// - A/C shutdown level: 1x tri-state, 01 high, 00 low
// - B/D shutdown level: 1x tri-state, 01 high, 00 low
// - hardware sets status bit 7 on shutdown; set bit holds outputs shut
// - with auto-restart on, status clears itself when the cause is gone
// - with auto-restart off, status stays set until software clears it
// - status set at period start holds shutdown levels for whole period
// - after status clears, pwm resumes only at next period start
// - software writes to status bit are ignored while a cause is active
// - comparator causes are levels; status cannot clear while cause persists
// - software writing one to status forces shutdown like a hardware event
// - mode bits 1:0 choose polarity for A/C and B/D pairs separately
`timescale 1ns/1ps
`include "pdas_defs.svh"

module pdas_top #(
	parameter int DB_W = 7
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// base pwm engine
	input wire logic pwm_raw,
	input wire logic period_start,
	// shutdown sources
	input wire logic fault_input_n,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	// bridge pins
	output logic bridge_out_a,
	output logic bridge_out_a_oe,
	output logic bridge_out_b,
	output logic bridge_out_b_oe,
	output logic bridge_out_c,
	output logic bridge_out_c_oe,
	output logic bridge_out_d,
	output logic bridge_out_d_oe
);
	import pdas_pkg::*;

	localparam int TCY_CLKS = `PDAS_TCY_PS / `PDAS_CLK_PERIOD_PS;
	localparam int CNT_W = DB_W + 3;

	// elaboration checks
	if (DB_W != `PDAS_DB_COUNT_MSB - `PDAS_DB_COUNT_LSB + 1)
	begin : g_chk_db_w
		$error("pdas_top: DB_W must match the dead-band field width");
	end
	if (TCY_CLKS != `PDAS_TOSC_PER_TCY)
	begin : g_chk_tcy
		$error("pdas_top: instruction cycle must be four clocks");
	end

	// registers
	logic [7:0] deadband_restart_ctrl_reg;
	logic [6:0] shutdown_cfg_reg;
	logic shutdown_event_status_reg;
	logic [7:0] pwm_mode_control_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// field views
	logic auto_restart_enable;
	logic [DB_W-1:0] dead_band_count;
	logic [2:0] shutdown_source_select;
	logic [1:0] pair_ac_shutdown_level;
	logic [1:0] pair_bd_shutdown_level;
	pdas_cfg_t output_config_select;
	logic pwm_enable;
	logic [1:0] pair_polarity_select;

	assign auto_restart_enable = deadband_restart_ctrl_reg[`PDAS_DB_RESTART_BIT];
	assign dead_band_count = deadband_restart_ctrl_reg[`PDAS_DB_COUNT_MSB:`PDAS_DB_COUNT_LSB];
	assign shutdown_source_select = shutdown_cfg_reg[`PDAS_AS_SRC_MSB:`PDAS_AS_SRC_LSB];
	assign pair_ac_shutdown_level = shutdown_cfg_reg[`PDAS_AS_AC_MSB:`PDAS_AS_AC_LSB];
	assign pair_bd_shutdown_level = shutdown_cfg_reg[`PDAS_AS_BD_MSB:`PDAS_AS_BD_LSB];
	assign output_config_select = pdas_cfg_t'(pwm_mode_control_reg[`PDAS_MC_CFG_MSB:`PDAS_MC_CFG_LSB]);
	assign pwm_enable = pwm_mode_control_reg[`PDAS_MC_ENABLE_BIT];
	assign pair_polarity_select = {pwm_mode_control_reg[`PDAS_MC_POL_BD_BIT],
		pwm_mode_control_reg[`PDAS_MC_POL_AC_BIT]};

	// apb decode
	logic apb_access;
	logic apb_wr;
	logic addr_hit;
	assign apb_access = psel & penable & ~pready_reg;
	// writes land at the completing edge, together with pready
	assign apb_wr = psel & penable & pready_reg & pwrite;
	always_comb
	begin
		case (paddr)
			`PDAS_OFS_DEADBAND,
			`PDAS_OFS_SHUTDOWN,
			`PDAS_OFS_MODE,
			`PDAS_OFS_STATUS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// source synchronisers
	logic [2:0] src_meta_reg;
	logic [2:0] src_sync_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_meta_reg <= 3'h0;
			src_sync_reg <= 3'h0;
		end
		else
		begin
			src_meta_reg <= {~fault_input_n, comparator2_out, comparator1_out};
			src_sync_reg <= src_meta_reg;
		end
	end

	// source selection, shared by the direct and synchronised paths
	function automatic logic src_select(input logic [2:0] sel, input logic flt,
		input logic c1, input logic c2);
		src_select = (sel[2] & flt) | (sel[0] & c1) | (sel[1] & c2);
	endfunction

	logic cause_async;
	logic cause_sync;
	assign cause_async = src_select(shutdown_source_select, ~fault_input_n,
		comparator1_out, comparator2_out);
	assign cause_sync = src_select(shutdown_source_select, src_sync_reg[2],
		src_sync_reg[0], src_sync_reg[1]);

	// status bit: set wins over any clear
	logic sw_status_wr;
	assign sw_status_wr = apb_wr & addr_hit & (paddr == `PDAS_OFS_SHUTDOWN);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shutdown_event_status_reg <= 1'(`PDAS_RST_SHUTDOWN >> `PDAS_AS_STATUS_BIT);
		else if (cause_sync)
			shutdown_event_status_reg <= 1'b1;
		else if (sw_status_wr && pwdata[`PDAS_AS_STATUS_BIT])
			shutdown_event_status_reg <= 1'b1;
		else if (sw_status_wr)
			shutdown_event_status_reg <= 1'b0;
		else if (auto_restart_enable)
			shutdown_event_status_reg <= 1'b0;
	end

	// period-aligned hold of the shutdown state
	logic hold_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_reg <= 1'b0;
		else if (shutdown_event_status_reg)
			hold_reg <= 1'b1;
		else if (period_start)
			hold_reg <= 1'b0;
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			deadband_restart_ctrl_reg <= `PDAS_RST_DEADBAND;
			shutdown_cfg_reg <= 7'(`PDAS_RST_SHUTDOWN);
			pwm_mode_control_reg <= `PDAS_RST_MODE;
		end
		else if (apb_wr)
		begin
			case (paddr)
				`PDAS_OFS_DEADBAND: deadband_restart_ctrl_reg <= pwdata[7:0];
				`PDAS_OFS_SHUTDOWN: shutdown_cfg_reg <= pwdata[6:0];
				`PDAS_OFS_MODE: pwm_mode_control_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// apb answer: one wait state, registered
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		case (paddr)
			`PDAS_OFS_DEADBAND: rd_mux = {24'h0, deadband_restart_ctrl_reg};
			`PDAS_OFS_SHUTDOWN: rd_mux = {24'h0, shutdown_event_status_reg, shutdown_cfg_reg};
			`PDAS_OFS_MODE: rd_mux = {24'h0, pwm_mode_control_reg};
			`PDAS_OFS_STATUS: rd_mux = {27'h0, cause_sync, hold_reg, src_sync_reg};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else
		begin
			pready_reg <= apb_access;
			pslverr_reg <= apb_access & ~addr_hit;
			prdata_reg <= (apb_access && !pwrite) ? rd_mux : 32'h0;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// dead-band sequencer
	pdas_db_state_t db_state_reg;
	logic [CNT_W-1:0] db_cnt_reg;
	logic [CNT_W-1:0] db_load;
	assign db_load = CNT_W'(dead_band_count) * CNT_W'(TCY_CLKS);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			db_state_reg <= PDAS_DB_B_ON;
			db_cnt_reg <= '0;
		end
		else
		begin
			case (db_state_reg)
				PDAS_DB_A_WAIT:
				begin
					if (!pwm_raw)
					begin
						db_state_reg <= PDAS_DB_B_WAIT;
						db_cnt_reg <= db_load;
					end
					else if (db_cnt_reg == '0)
						db_state_reg <= PDAS_DB_A_ON;
					else
						db_cnt_reg <= db_cnt_reg - 1'b1;
				end
				PDAS_DB_A_ON:
				begin
					if (!pwm_raw)
					begin
						db_state_reg <= PDAS_DB_B_WAIT;
						db_cnt_reg <= db_load;
					end
				end
				PDAS_DB_B_WAIT:
				begin
					if (pwm_raw)
					begin
						db_state_reg <= PDAS_DB_A_WAIT;
						db_cnt_reg <= db_load;
					end
					else if (db_cnt_reg == '0)
						db_state_reg <= PDAS_DB_B_ON;
					else
						db_cnt_reg <= db_cnt_reg - 1'b1;
				end
				PDAS_DB_B_ON:
				begin
					if (pwm_raw)
					begin
						db_state_reg <= PDAS_DB_A_WAIT;
						db_cnt_reg <= db_load;
					end
				end
				default:
				begin
					db_state_reg <= PDAS_DB_B_ON;
					db_cnt_reg <= '0;
				end
			endcase
		end
	end

	// steering of the active levels per configuration
	logic [3:0] act_next;
	logic [3:0] oe_next;
	logic [3:0] act_reg;
	logic [3:0] oe_reg;
	always_comb
	begin
		act_next = 4'h0;
		oe_next = 4'h0;
		case (output_config_select)
			PDAS_CFG_SINGLE:
			begin
				act_next = {3'h0, pwm_raw};
				oe_next = 4'h1;
			end
			PDAS_CFG_HALF:
			begin
				act_next = {2'h0, db_state_reg == PDAS_DB_B_ON,
					db_state_reg == PDAS_DB_A_ON};
				oe_next = 4'h3;
			end
			PDAS_CFG_FULL_FWD:
			begin
				act_next = {pwm_raw, 3'h1};
				oe_next = 4'hF;
			end
			PDAS_CFG_FULL_REV:
			begin
				act_next = {1'b0, 1'b1, pwm_raw, 1'b0};
				oe_next = 4'hF;
			end
			default:
			begin
				act_next = 4'h0;
				oe_next = 4'h0;
			end
		endcase
		if (!pwm_enable)
			oe_next = 4'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_reg <= 4'h0;
			oe_reg <= 4'h0;
		end
		else
		begin
			act_reg <= act_next ^ {pair_polarity_select[1], pair_polarity_select[0],
				pair_polarity_select[1], pair_polarity_select[0]};
			oe_reg <= oe_next;
		end
	end

	// pin forcing is combinational so a fault acts without a clock edge
	logic shut_now;
	logic [1:0] ac_lvl;
	logic [1:0] bd_lvl;
	assign shut_now = cause_async | shutdown_event_status_reg | hold_reg;
	assign ac_lvl = pair_ac_shutdown_level;
	assign bd_lvl = pair_bd_shutdown_level;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_pin
			logic [1:0] lvl;
			logic pin_val;
			logic pin_oe;
			assign lvl = (gi % 2 == 1) ? bd_lvl : ac_lvl;
			assign pin_val = shut_now ? (lvl == 2'h1) : act_reg[gi];
			assign pin_oe = oe_reg[gi] & ~(shut_now & lvl[1]);
		end
	endgenerate

	assign bridge_out_a = g_pin[0].pin_val;
	assign bridge_out_a_oe = g_pin[0].pin_oe;
	assign bridge_out_b = g_pin[1].pin_val;
	assign bridge_out_b_oe = g_pin[1].pin_oe;
	assign bridge_out_c = g_pin[2].pin_val;
	assign bridge_out_c_oe = g_pin[2].pin_oe;
	assign bridge_out_d = g_pin[3].pin_val;
	assign bridge_out_d_oe = g_pin[3].pin_oe;

endmodule

// File: dv/pdas_bridge_model.sv
`timescale 1ns/1ps
module pdas_bridge_model #(
	parameter int PERIOD = 64
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// high time of the raw waveform in clocks
	input wire logic [7:0] duty,
	// base engine outputs
	output logic pwm_raw,
	output logic period_start
);
	logic [7:0] cnt_reg;

	// start pulse and raw level both come from one counter, so they never skew
	always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		cnt_reg <= 8'h00;
		pwm_raw <= 1'b0;
		period_start <= 1'b0;
	end
	else
	begin
		cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
		period_start <= (cnt_reg == 8'h00);
		pwm_raw <= (cnt_reg < duty);
	end
endmodule

// File: dv/pdas_assertions.sv
`timescale 1ns/1ps
module pdas_assertions (
	// clock, reset, apb
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	// engine, causes, pins
	input wire logic pwm_raw, period_start, fault_input_n, comparator1_out, comparator2_out,
	input wire logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe,
	input wire logic bridge_out_c, bridge_out_c_oe, bridge_out_d, bridge_out_d_oe
);
	logic [7:0] db_reg;
	logic [7:0] as_reg;
	logic [7:0] md_reg;
	logic cause;

	// shadows update on the same edge as the design registers; stimulus keeps settings quiet near causes
	always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		db_reg <= 8'h00;
		as_reg <= 8'h00;
		md_reg <= 8'h00;
	end
	else if (psel && penable && pready && pwrite)
	begin
		if (paddr == 8'h00)
			db_reg <= pwdata[7:0];
		if (paddr == 8'h04)
			as_reg <= pwdata[7:0];
		if (paddr == 8'h08)
			md_reg <= pwdata[7:0];
	end
	assign cause = (as_reg[4] && comparator1_out) || (as_reg[5] && comparator2_out)
		|| (as_reg[6] && !fault_input_n);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_fault_force;
		as_reg[6] && !fault_input_n && bridge_out_a_oe && !as_reg[3] && !md_reg[0]
			|-> bridge_out_a == as_reg[2];
	endproperty
	a_fault_force: assert property (p_fault_force) else $error("pin a not forced");
	property p_ac_tri;
		cause && as_reg[3] |-> !bridge_out_a_oe && !bridge_out_c_oe;
	endproperty
	a_ac_tri: assert property (p_ac_tri) else $error("pair ac still driven");
	property p_bd_level;
		cause && !as_reg[1] && bridge_out_b_oe && !md_reg[1] |-> bridge_out_b == as_reg[0];
	endproperty
	a_bd_level: assert property (p_bd_level) else $error("pin b wrong level");
	property p_latch;
		$fell(cause) && !db_reg[7] && !as_reg[1] && !md_reg[1] && bridge_out_b_oe
			|-> (bridge_out_b == as_reg[0]) [*8];
	endproperty
	a_latch: assert property (p_latch) else $error("shutdown not held");
	property p_restart;
		$fell(cause) && db_reg[7] && as_reg[3] && md_reg[3] |-> ##[1:140] bridge_out_a_oe;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_resume;
		$rose(bridge_out_a_oe) && as_reg[3] && md_reg[3] && $past(md_reg[3], 2)
			|-> $past(period_start);
	endproperty
	a_resume: assert property (p_resume) else $error("resumed off period");
	property p_rd_deadband;
		psel && penable && pready && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, db_reg};
	endproperty
	a_rd_deadband: assert property (p_rd_deadband) else $error("bad readback");
	property p_no_overlap;
		md_reg[7:6] == 2'h1 && md_reg[1:0] == 2'h0 && as_reg[3:0] != 4'h5 && bridge_out_a_oe
			&& bridge_out_b_oe |-> !(bridge_out_a && bridge_out_b);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("a and b overlap");
endmodule

bind pdas_top pdas_assertions u_chk (.*);

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int P = 64;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic fault_input_n = 1, comparator1_out = 0, comparator2_out = 0;
	logic [7:0] paddr = 0, duty = 8'h18;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, pwm_raw, period_start, err, hit;
	logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
	logic bridge_out_c, bridge_out_c_oe, bridge_out_d, bridge_out_d_oe;
	logic [3:0] lv;
	logic [2:0] cv;
	int errors = 0, n_tests = 0, seed = 32'h0ec8, ha, hb, h1, h2;

	pdas_top u_dut (.*);
	pdas_bridge_model #(.PERIOD(P)) u_far (.*);

	always #12.5 pclk = ~pclk;

	task automatic stop_test();
	if (errors == 0 && n_tests > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
	endtask

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
	n_tests++;
	if (seen !== exp)
	begin
		errors++;
		$display("ERROR %s expected %0h seen %0h", what, exp, seen);
	end
	endtask

	task automatic cyc(int n);
	repeat (n) @(posedge pclk);
	endtask

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
	int i = 0;
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	do
	begin
		@(posedge pclk);
		i++;
	end
	while (pready !== 1'b1 && i < 20);
	if (i >= 20)
	begin
		errors++;
		stop_test();
	end
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	endtask

	task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
	apb(1'b0, a, 32'h0);
	chk(what, rd, exp);
	endtask

	task automatic wait_ps();
	int i = 0;
	do
	begin
		@(posedge pclk);
		i++;
	end
	while (period_start !== 1'b1 && i < 200);
	if (i >= 200)
	begin
		errors++;
		stop_test();
	end
	endtask

	// high time of a and b over one full period once the waveform has settled
	task automatic meas();
	ha = 0;
	hb = 0;
	cyc(2 * P);
	repeat (P)
	begin
		@(posedge pclk);
		ha += (bridge_out_a === 1'b1 && bridge_out_a_oe === 1'b1);
		hb += (bridge_out_b === 1'b1 && bridge_out_b_oe === 1'b1);
	end
	endtask

	function automatic logic [1:0] pin_exp(logic [1:0] l);
		return l[1] ? 2'b00 : {1'b1, l[0]};
	endfunction

	initial
	begin
		cyc(8);
		presetn <= 1'b1;
		rdchk("deadband", 8'h00, 0);
		rdchk("shutdown", 8'h04, 0);
		apb(1'b1, 8'h00, 32'hFF);
		rdchk("deadband rw", 8'h00, 32'hFF);
		apb(1'b0, 8'h10, 0);
		chk("unmapped err", err, 1);
		apb(1'b1, 8'h08, 32'h08);
		meas();
		h1 = ha;
		apb(1'b1, 8'h08, 32'h01);
		apb(1'b1, 8'h08, 32'h09);
		meas();
		chk("polarity", ha + h1, P);
		apb(1'b1, 8'h00, 32'h01);
		apb(1'b1, 8'h08, 32'h48);
		meas();
		h1 = ha;
		h2 = hb;
		apb(1'b1, 8'h00, 32'h03);
		meas();
		chk("a dead band", h1 - ha, 8);
		chk("b dead band", h2 - hb, 8);
		apb(1'b1, 8'h00, 32'h28);
		meas();
		chk("a long band", ha, 0);
		chk("b long band", hb, 0);
		apb(1'b1, 8'h00, 32'h80);
		for (int i = 0; i < 32; i++)
		begin
			lv = 4'($random(seed));
			cv = 3'($random(seed));
			apb(1'b1, 8'h08, {i[1:0], 6'h08});
			apb(1'b1, 8'h04, {25'h0, i[4:2], lv});
			hit = |(i[4:2] & cv);
			@(posedge pclk);
			fault_input_n <= !cv[2];
			comparator2_out <= cv[1];
			comparator1_out <= cv[0];
			#1;
			if (hit)
			begin
				chk("a forced", {bridge_out_a_oe, bridge_out_a & bridge_out_a_oe}, pin_exp(lv[3:2]));
				if (i[1:0] != 2'h0)
					chk("b forced", {bridge_out_b_oe, bridge_out_b & bridge_out_b_oe}, pin_exp(lv[1:0]));
				if (i[1])
				begin
					chk("c forced", {bridge_out_c_oe, bridge_out_c & bridge_out_c_oe}, pin_exp(lv[3:2]));
					chk("d forced", {bridge_out_d_oe, bridge_out_d & bridge_out_d_oe}, pin_exp(lv[1:0]));
				end
			end
			cyc(6);
			rdchk("status set", 8'h04, {hit, i[4:2], lv});
			@(posedge pclk);
			fault_input_n <= 1'b1;
			comparator2_out <= 1'b0;
			comparator1_out <= 1'b0;
			cyc(6);
			rdchk("status clear", 8'h04, {i[4:2], lv});
			cyc(2 * P);
		end
		apb(1'b1, 8'h00, 0);
		apb(1'b1, 8'h04, 32'h49);
		@(posedge pclk);
		fault_input_n <= 1'b0;
		cyc(6);
		apb(1'b1, 8'h04, 32'h49);
		rdchk("write ignored", 8'h04, 32'hC9);
		@(posedge pclk);
		fault_input_n <= 1'b1;
		cyc(12);
		rdchk("status kept", 8'h04, 32'hC9);
		wait_ps();
		apb(1'b1, 8'h04, 32'h49);
		cyc(2);
		#1;
		chk("held to period end", bridge_out_a_oe, 0);
		cyc(P + 4);
		chk("resumed", bridge_out_a_oe, 1);
		apb(1'b1, 8'h04, 32'hC9);
		cyc(2);
		chk("forced by write", bridge_out_a_oe, 0);
		stop_test();
	end
endmodule
